/* hw/atn_consts.vh */
// constants for the antenna tuner interface block
`ifndef ATN_CONSTS_VH
`define ATN_CONSTS_VH
`define ATN_ADDR_CTRL     12'h000
`define ATN_ADDR_CHAN     12'h004
`define ATN_ADDR_FREQ     12'h008
`define ATN_ADDR_STATUS   12'h00C
`define ATN_ADDR_IRQ_STAT 12'h010
`define ATN_ADDR_IRQ_EN   12'h014
`define ATN_ADDR_IRQ_CLR  12'h018
`define ATN_ADDR_SWR      12'h01C
`define ATN_ADDR_POWER    12'h020
`define ATN_CTRL_BANDMODE 0
`define ATN_CTRL_SPECIAL  1
`define ATN_CTRL_SCAN     2
`define ATN_CTRL_TXKEY    3
`define ATN_CTRL_TEST     4
`define ATN_CTRL_TUNE_GO  5
`define ATN_CTRL_RESET    8'h00
`define ATN_FREQ_RESET    16'h0000
`define ATN_CHAN_RESET    8'h00
`define ATN_BAND_B2       16'h07D0
`define ATN_BAND_B3       16'h0BB8
`define ATN_BAND_B4       16'h1388
`define ATN_BAND_B5       16'h1F40
`define ATN_BAND_B6       16'h32C8
`define ATN_BAND_B7       16'h4E20
`define ATN_IRQ_OK        0
`define ATN_IRQ_FAIL      1
`define ATN_IRQ_START     2
`define ATN_IRQ_WIDTH     3
`define ATN_SYNC_STAGES   2
`endif

/* hw/atn_sync2.v */
// two-stage synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module atn_sync2 (
  input  wire pclk,
  input  wire presetn,
  input  wire set_val,
  input  wire din,
  output reg  dout
);
  reg stage1_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_r <= 1'b1;
      dout     <= 1'b1;
    end else begin
      stage1_r <= din;
      dout     <= stage1_r;
    end
  end
  wire unused_set = set_val;
endmodule
`default_nettype wire

/* hw/atn_tuner_if.v */
// antenna tuner control port with apb register access
//
// Behaviour
// RL1 - four-bit code: three select bits, one special
// RL2 - channel mode: channel modulo nine, low bits
// RL3 - band mode: frequency thresholds give band 1..7
// RL4 - stay in tune while request line held low
// RL5 - sample result at end; high success, low fail
// RL6 - scan line low in scan mode
// RL7 - transmit key output active high when keyed
// RL8 - tune compares forward and reflected power
// RL9 - tuner inputs pass two-stage synchronisers
// RL10 - code registered, updated only on selection change
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "atn_consts.vh"
module atn_tuner_if (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [3:0]  antenna_code,
  input  wire        tune_req_in,
  output reg         tune_req_out,
  output reg         tune_req_oe,
  input  wire        tune_result_line,
  output reg         scan_select_n,
  output reg         transmit_key,
  input  wire [7:0]  forward_power_level,
  input  wire [7:0]  reflected_power_level,
  output reg         irq
);
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_START = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  reg [7:0]  ctrl_r;
  reg [7:0]  chan_r;
  reg [15:0] freq_r;
  reg [2:0]  irq_stat_r;
  reg [2:0]  irq_en_r;
  reg [3:0]  state_r;
  reg        result_r;
  reg        tuned_r;
  reg [7:0]  fwd_r;
  reg [7:0]  refl_r;
  reg        swr_bad_r;
  reg [3:0]  code_nxt;
  reg [3:0]  state_nxt;
  reg [2:0]  ev_set;
  reg [31:0] rd_nxt;
  reg        err_nxt;
  wire       req_sync;
  wire       res_sync;
  wire       setup_ph;
  wire       wr_acc;

  // band number from frequency in kHz
  function [2:0] band_of;
    input [15:0] khz;
    begin
      if (khz < `ATN_BAND_B2)
        band_of = 3'h1; // RL3
      else if (khz < `ATN_BAND_B3)
        band_of = 3'h2;
      else if (khz < `ATN_BAND_B4)
        band_of = 3'h3;
      else if (khz < `ATN_BAND_B5)
        band_of = 3'h4;
      else if (khz < `ATN_BAND_B6)
        band_of = 3'h5;
      else if (khz < `ATN_BAND_B7)
        band_of = 3'h6;
      else
        band_of = 3'h7;
    end
  endfunction

  // channel code repeats every nine channels: 9 gives 0, 10 gives 1
  function [2:0] chan_code;
    input [7:0] chan;
    reg   [7:0] rem;
    begin
      rem       = chan % 8'h09;
      chan_code = rem[2:0]; // RL2
    end
  endfunction

  atn_sync2 u_sync_req ( // RL9
    .pclk    (pclk),
    .presetn (presetn),
    .set_val (1'b1),
    .din     (tune_req_in),
    .dout    (req_sync)
  );

  atn_sync2 u_sync_res ( // RL9
    .pclk    (pclk),
    .presetn (presetn),
    .set_val (1'b1),
    .din     (tune_result_line),
    .dout    (res_sync)
  );

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;

  always @* begin
    if (ctrl_r[`ATN_CTRL_BANDMODE])
      code_nxt = {ctrl_r[`ATN_CTRL_SPECIAL], band_of(freq_r)};
    else
      code_nxt = {ctrl_r[`ATN_CTRL_SPECIAL], chan_code(chan_r)}; // RL2
  end

  // tune sequence
  always @* begin
    state_nxt = state_r;
    ev_set    = 3'h0;
    case (state_r)
      ST_IDLE: begin
        if (wr_acc && paddr == `ATN_ADDR_CTRL &&
            pwdata[`ATN_CTRL_TUNE_GO]) begin
          state_nxt = ST_START;
          ev_set[`ATN_IRQ_START] = 1'b1;
        end
      end
      ST_START: begin
        if (!req_sync)
          state_nxt = ST_WAIT; // RL4
      end
      ST_WAIT: begin
        if (req_sync)
          state_nxt = ST_DONE; // RL4
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
        if (res_sync)
          ev_set[`ATN_IRQ_OK] = 1'b1; // RL5
        else
          ev_set[`ATN_IRQ_FAIL] = 1'b1; // RL5
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `ATN_ADDR_CTRL)
      rd_nxt = {24'h000000, ctrl_r};
    else if (paddr == `ATN_ADDR_CHAN)
      rd_nxt = {24'h000000, chan_r};
    else if (paddr == `ATN_ADDR_FREQ)
      rd_nxt = {16'h0000, freq_r};
    else if (paddr == `ATN_ADDR_STATUS)
      rd_nxt = {24'h000000, state_r, antenna_code[2:0], result_r};
    else if (paddr == `ATN_ADDR_IRQ_STAT)
      rd_nxt = {29'h00000000, irq_stat_r};
    else if (paddr == `ATN_ADDR_IRQ_EN)
      rd_nxt = {29'h00000000, irq_en_r};
    else if (paddr == `ATN_ADDR_IRQ_CLR)
      rd_nxt = 32'h0000_0000;
    else if (paddr == `ATN_ADDR_SWR)
      rd_nxt = {ctrl_r[`ATN_CTRL_TEST] ? {15'h0000, swr_bad_r} : 16'h0000,
                refl_r, fwd_r}; // RL8
    else if (paddr == `ATN_ADDR_POWER)
      rd_nxt = {15'h0000, tuned_r, reflected_power_level,
                forward_power_level};
    else
      err_nxt = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r        <= `ATN_CTRL_RESET;
      chan_r        <= `ATN_CHAN_RESET;
      freq_r        <= `ATN_FREQ_RESET;
      irq_stat_r    <= 3'h0;
      irq_en_r      <= 3'h0;
      state_r       <= ST_IDLE;
      result_r      <= 1'b0;
      tuned_r       <= 1'b0;
      fwd_r         <= 8'h00;
      refl_r        <= 8'h00;
      swr_bad_r     <= 1'b0;
      prdata        <= 32'h0000_0000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      antenna_code  <= 4'h0;
      tune_req_out  <= 1'b0;
      tune_req_oe   <= 1'b0;
      scan_select_n <= 1'b1;
      transmit_key  <= 1'b0;
      irq           <= 1'b0;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & err_nxt;
      if (setup_ph)
        prdata <= rd_nxt;
      if (wr_acc) begin
        if (paddr == `ATN_ADDR_CTRL)
          ctrl_r <= {2'b00, 1'b0, pwdata[4:0]};
        else if (paddr == `ATN_ADDR_CHAN)
          chan_r <= pwdata[7:0];
        else if (paddr == `ATN_ADDR_FREQ)
          freq_r <= pwdata[15:0];
        else if (paddr == `ATN_ADDR_IRQ_EN)
          irq_en_r <= pwdata[2:0];
      end
      // set wins over clear
      if (wr_acc && paddr == `ATN_ADDR_IRQ_CLR)
        irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | ev_set;
      else
        irq_stat_r <= irq_stat_r | ev_set;
      irq <= |((irq_stat_r | ev_set) & irq_en_r);
      state_r <= state_nxt;
      if (state_r == ST_DONE) begin
        result_r <= res_sync; // RL5
        tuned_r  <= 1'b1;
      end
      if (state_r == ST_WAIT) begin
        fwd_r     <= forward_power_level; // RL8
        refl_r    <= reflected_power_level;
        swr_bad_r <= (reflected_power_level >
                      {1'b0, forward_power_level[7:1]}); // RL8
      end
      // drive low briefly to start, then release for tuner to hold
      tune_req_out <= 1'b0;
      tune_req_oe  <= (state_nxt == ST_START); // RL4
      if (code_nxt != antenna_code)
        antenna_code <= code_nxt; // RL10 RL1
      scan_select_n <= ~ctrl_r[`ATN_CTRL_SCAN]; // RL6
      transmit_key  <= ctrl_r[`ATN_CTRL_TXKEY]; // RL7
    end
  end
endmodule
`default_nettype wire

/* testbench/atn_props.sv */
// concurrent checks on the antenna tuner port
`timescale 1ns/100ps
`default_nettype none
module atn_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  antenna_code,
  input wire logic        tune_req_out,
  input wire logic        tune_req_oe,
  input wire logic        scan_select_n,
  input wire logic        transmit_key
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] quiet_r;
  wire        ctl_acc = psel && penable && pwrite && paddr == 12'h000;
  wire        sel_acc = psel && penable && pwrite && paddr <= 12'h008;
  // cycles since the last write that may move the code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      quiet_r <= 3'h7;
    else if (sel_acc)
      quiet_r <= 3'h0;
    else if (quiet_r != 3'h7)
      quiet_r <= quiet_r + 3'h1;
  end
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence go_s;
    ctl_acc && pwdata[5];
  endsequence
  AST_PREADY_PULSE: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not a one-cycle answer");
  AST_SLVERR_PAIR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_SCAN_ON: assert property (
    ctl_acc && pwdata[2] |-> ##[1:3] !scan_select_n)
    else $error("scan line not low");
  AST_SCAN_OFF: assert property (
    ctl_acc && !pwdata[2] |-> ##[1:3] scan_select_n)
    else $error("scan line not high");
  AST_TXKEY_ON: assert property (
    ctl_acc && pwdata[3] |-> ##[1:3] transmit_key)
    else $error("transmit key not high");
  AST_TXKEY_OFF: assert property (
    ctl_acc && !pwdata[3] |-> ##[1:3] !transmit_key)
    else $error("transmit key not low");
  AST_TUNE_GO: assert property (go_s |-> ##[1:3] tune_req_oe)
    else $error("tune request not pulled");
  AST_OD_LOW: assert property (tune_req_out == 1'b0)
    else $error("tune line driven high");
  AST_CODE_HOLD: assert property (
    quiet_r == 3'h7 |-> $stable(antenna_code))
    else $error("antenna code moved without a write");
endmodule
`default_nettype wire

/* testbench/atn_tuner_model.sv */
// automatic tuner on the far side of the tune lines
`timescale 1ns/100ps
`default_nettype none
module atn_tuner_model (
  input  wire logic       pclk,
  input  wire logic       tune_req_in,
  input  wire logic       ok,
  input  wire logic [7:0] hold,
  output var  logic       hold_n,
  output var  logic       tune_result_line
);
  initial begin
    hold_n = 1'b1;
    tune_result_line = 1'b0;
    forever begin
      @(posedge pclk);
      if (!tune_req_in) begin
        hold_n <= 1'b0;
        repeat (hold) @(posedge pclk);
        tune_result_line <= ok;
        @(posedge pclk);
        hold_n <= 1'b1;
        repeat (4) @(posedge pclk);
        tune_result_line <= !ok;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the antenna tuner port
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, ok = 1'b1, hold_n, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [7:0] forward_power_level = 8'h00, reflected_power_level = 8'h00;
  logic [7:0] hold = 8'h1E;
  logic [3:0] antenna_code;
  logic pready, pslverr, tune_req_out, tune_req_oe, scan_select_n;
  logic transmit_key, irq, tune_result_line;
  int n_mismatch = 0, tests_run = 0;
  int fq[12] = '{1999, 2000, 2999, 3000, 4999, 5000, 7999, 8000, 12999,
                 13000, 19999, 20000};
  int ch[3] = '{1, 9, 10}, ce[3] = '{1, 0, 1};
  wire tune_req_in = !tune_req_oe && hold_n;
  always #12.5 pclk = ~pclk;
  atn_tuner_if u_atn_tuner_if (.*);
  atn_tuner_model u_atn_tuner_model (.*);
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdata);
  endtask
  task code_is(input logic [3:0] e);
    repeat (3) @(posedge pclk);
    chk("code", {28'h0, e}, {28'h0, antenna_code});
  endtask
  task tune_wait;
    int n;
    n = 0;
    do apb(1'b0, 12'h010, 32'h0); while (rdata[1:0] == 2'b00 && ++n < 40);
  endtask
  function automatic logic [3:0] band(input int f);
    band = f < 2000 ? 1 : f < 3000 ? 2 : f < 5000 ? 3 : f < 8000 ? 4 :
           f < 13000 ? 5 : f < 20000 ? 6 : 7;
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    chk("idle", 32'h80, {scan_select_n, transmit_key, tune_req_oe, irq,
        antenna_code});
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(12'h004, ch[i]);
      code_is(ce[i][3:0]);
    end
    wr(12'h000, 32'h2);
    code_is(4'h9);
    wr(12'h000, 32'h1);
    for (int i = 0; i < 12; i++) begin
      wr(12'h008, fq[i]);
      code_is(band(fq[i]));
    end
    wr(12'h000, 32'hC);
    code_is(4'h1);
    chk("scan tx", 32'h1, {scan_select_n, transmit_key});
    wr(12'h000, 32'h0);
    code_is(4'h1);
    chk("scan tx", 32'h2, {scan_select_n, transmit_key});
    wr(12'h014, 32'h7);
    wr(12'h000, 32'h20);
    rd(12'h010, 32'h4, "busy");
    tune_wait;
    chk("tuned", 32'h5, rdata);
    chk("irq", 32'h1, irq);
    wr(12'h014, 32'h0);
    code_is(4'h1);
    chk("masked", 32'h0, irq);
    wr(12'h018, 32'h7);
    rd(12'h010, 32'h0, "clear");
    ok <= 1'b0;
    forward_power_level <= 8'h40;
    reflected_power_level <= 8'h30;
    wr(12'h000, 32'h20);
    tune_wait;
    chk("failed", 32'h6, rdata);
    wr(12'h000, 32'h10);
    rd(12'h01C, 32'h13040, "swr");
    apb(1'b0, 12'h024, 32'h0);
    chk("slverr", 32'h1, rerr);
    tally_and_finish;
  end
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
bind atn_tuner_if atn_props u_atn_props (.*);
`default_nettype wire
